// file: rtl/port_line_pkg.sv
// Purpose: Shared constants and types for the port session line control block
// Assumes: Clock of 10 MHz; one port per instance
// Notes:   Status and config codes are local encodings
package port_line_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 10_000_000;
  // ==========================================================
  // Characters and defaults
  localparam logic [7:0] CHR_ESC     = 8'h1b;
  localparam logic [7:0] CHR_DEL     = 8'h7f;
  localparam logic [7:0] CHR_CR      = 8'h0d;
  localparam logic [7:0] CHR_XON     = 8'h11;
  localparam logic [7:0] CHR_XOFF    = 8'h13;
  localparam logic [7:0] CHR_SPACE   = 8'h20;
  localparam logic [7:0] IDLE_DEF    = 8'h05;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [5:0] CMD_ENABLE  = 6'h0b;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {ENTRY_IDLE = 2'h0, ENTRY_BREAK = 2'h1, ENTRY_SEQ = 2'h2} entry_t;
  typedef enum logic [1:0] {DTR_OFF = 2'h0, DTR_ON = 2'h1, DTR_TIMED = 2'h2} dtr_t;
  typedef enum logic [1:0] {EOM_NONE = 2'h0, EOM_NEWLINE = 2'h1, EOM_CONTROL = 2'h2} eom_t;
  typedef enum logic [1:0] {FLOW_NONE = 2'h0, FLOW_PINS = 2'h1, FLOW_XON = 2'h2} flow_t;
  // ==========================================================
  // Configuration items
  typedef enum logic [3:0] {
    CFG_ENTRY = 4'h0, CFG_ENTRY_SEQ = 4'h1, CFG_DCD = 4'h2, CFG_DTR = 4'h3,
    CFG_ECHO = 4'h4, CFG_EOM = 4'h5, CFG_EOM_CNT = 4'h6, CFG_EXPAND = 4'h7,
    CFG_NEWLINE = 4'h8, CFG_FLOW = 4'h9, CFG_IDLE = 4'ha, CFG_DISABLE = 4'hb,
    CFG_ENABLE = 4'hc
  } cfg_item_t;
  // ==========================================================
  // Call events from the session machinery
  typedef enum logic [2:0] {
    EV_PORT_BUSY = 3'h0, EV_ROTARY_NONE = 3'h1, EV_PORT_FULL = 3'h2, EV_REMOTE_FULL = 3'h3,
    EV_UNIT_FULL = 3'h4, EV_NO_REPLY = 3'h5, EV_OPEN_ACK = 3'h6
  } call_ev_t;
  // Outcome codes
  typedef enum logic [3:0] {
    ST_NONE = 4'h0, ST_PORTS_BUSY = 4'h1, ST_PORT_FULL = 4'h2, ST_REMOTE_FULL = 4'h3,
    ST_UNIT_FULL = 4'h4, ST_NO_RESP = 4'h5, ST_UNEXP_ACK = 4'h6, ST_CALL_OK = 4'h7,
    ST_CLOSED = 4'h8, ST_ABORTED = 4'h9, ST_PARAM_ERR = 4'ha
  } status_t;
endpackage

// file: rtl/port_session_line_control.sv
// Purpose: Per-port line control between a serial user device and the session machinery
// Assumes: Rx bytes arrive from a UART on clk; DTR is an asynchronous pin
// Notes:   Config changes arrive as item/value writes with an ok/error answer
// Operation
// - Specific port refusing or no free rotary port reports ports busy.
// - Port, remote unit, local unit session exhaustion each report distinct failures.
// - No reply to session open ends the call with no-response failure.
// - Open acknowledge without an outstanding open flags unexpected acknowledge.
// - Command entry by idle-only, break, or two-byte sequence; change applies at once.
// - Reset entry sequence is escape then delete.
// - DCD always asserted unless control on; then asserted while sessions exist.
// - Disabled commands rejected unless privileged; disabling unknown name gives error.
// - Enabling unknown name gives parameter error and nothing else.
// - Close by number, or current session when terminated properly.
// - Close reports closed, aborted, or parameter error for bad number.
// - DTR falling with control or timeout set terminates all sessions.
// - DTR low with control set refuses incoming sessions.
// - Timeout mode rings and waits x ticks of 10 ms for DTR; 1-255.
// - DTR control off: sessions proceed; ring while DTR absent, drop on DTR.
// - Outgoing calls allowed under every DTR setting.
// - Local echo returns each received byte except one taken while an xon/xoff byte is sent; off after reset.
// - End of message marks stream and forwards packet; default none, count zero.
// - Newline/control modes end packet on match or count; count needs mode.
// - Expansion echoes expansion byte on newline and drops newline; off after reset.
// - Flow control none, pins, or xon/xoff; xon/xoff after reset.
// - Idle timer restarts per byte, forwards on expiry; 10 ms units, default 5.
// - Newline byte configurable, default carriage return.
`timescale 1ns/1ps

// ==========================================================
// Byte FIFO
module line_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  room
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_st_t;
  fifo_st_t             s_q, s_d;
  logic [WIDTH-1:0]     mem [DEPTH];
  logic                 push;
  logic                 pop;

  assign in_ready  = s_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_q.cnt != '0;
  assign out_data  = mem[s_q.rd];
  assign room      = s_q.cnt < (AW+1)'(DEPTH - 1);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) s_d.wr = s_q.wr + 1'b1;
    if (pop) s_d.rd = s_q.rd + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) s_q <= '0;
    else s_q <= s_d;
  end

  always_ff @(posedge clk) begin
    if (push) mem[s_q.wr] <= in_data;
  end
endmodule // line_fifo

// ==========================================================
// Line control
module port_session_line_control
  import port_line_pkg::*;
#(
  parameter int NUM_CMDS    = 36,
  parameter int FIFO_DEPTH  = 32,
  parameter int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    cfg_valid,
  input  wire port_line_pkg::cfg_item_t cfg_item,
  input  wire logic [15:0]             cfg_value,
  output logic                         cfg_ok,
  output logic                         cfg_err,
  input  wire logic                    cmd_valid,
  input  wire logic [5:0]              cmd_id,
  input  wire logic                    cmd_priv,
  output logic                         cmd_accept,
  output logic                         cmd_reject,
  input  wire logic [4:0]              sess_count,
  input  wire logic                    open_pending,
  input  wire logic                    call_ev_valid,
  input  wire port_line_pkg::call_ev_t call_ev,
  input  wire logic                    close_valid,
  input  wire logic                    close_num_given,
  input  wire logic [3:0]              close_num,
  input  wire logic                    close_term_ok,
  input  wire logic                    close_ans_valid,
  input  wire logic                    close_answered,
  output logic                         close_go,
  output logic [3:0]                   close_sel,
  output port_line_pkg::status_t       status_code,
  output logic                         status_valid,
  input  wire logic                    dtr_pin,
  input  wire logic                    in_call_valid,
  output logic                         in_call_accept,
  output logic                         in_call_refuse,
  output logic                         kill_all,
  output logic                         ri,
  output logic                         dcd,
  output logic                         cts,
  output logic                         cmd_mode_enter,
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_data,
  input  wire logic                    rx_break,
  output logic                         rx_ready,
  output logic                         tx_valid,
  output logic [7:0]                   tx_data,
  output logic                         pkt_flush,
  output logic                         net_valid,
  input  wire logic                    net_ready,
  output logic [7:0]                   net_data,
  output logic                         net_eom
);
  import port_line_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef struct packed {
    entry_t                entry;
    logic [7:0]            seq1;
    logic [7:0]            seq2;
    logic                  dcd_ctl;
    dtr_t                  dtr_mode;
    logic [7:0]            dtr_to;
    logic                  echo;
    eom_t                  eom_mode;
    logic [7:0]            eom_cnt;
    logic                  exp_on;
    logic [7:0]            exp_ch;
    logic [7:0]            nl_ch;
    flow_t                 flow;
    logic [7:0]            idle;
    logic [NUM_CMDS-1:0]   dis;
    logic                  cfg_ok;
    logic                  cfg_err;
    logic                  cmd_ok;
    logic                  cmd_rej;
    logic                  close_go;
    logic [3:0]            close_sel;
    status_t               stat;
    logic                  stat_v;
    logic [7:0]            last;
    logic                  enter;
    logic                  dtr_s1;
    logic                  dtr_s2;
    logic                  dtr_old;
    logic                  ri;
    logic                  ring;
    logic [7:0]            ring_cnt;
    logic [TW-1:0]         tick_cnt;
    logic                  in_acc;
    logic                  in_ref;
    logic                  kill;
    logic                  dcd;
    logic                  tx_v;
    logic [7:0]            tx_d;
    logic                  xoff_sent;
    logic                  cts;
    logic [7:0]            pkt_len;
    logic [7:0]            idle_cnt;
    logic                  flush;
    logic                  rx_rdy;
  } state_t;

  state_t     s_q, s_d;
  logic       tick, take, is_nl, is_ctl, eom_hit, push, echo_go, flow_go, fifo_room, fifo_in_rdy;
  logic [7:0] flow_ch;
  logic       id_ok;

  assign tick    = s_q.tick_cnt == TICK_LAST;
  assign take    = rx_valid && s_q.rx_rdy && fifo_in_rdy;
  assign is_nl   = rx_data == s_q.nl_ch;
  assign is_ctl  = rx_data < CHR_SPACE || rx_data == CHR_DEL;
  assign id_ok   = cfg_value[15:6] == '0 && int'(cfg_value[5:0]) < NUM_CMDS;
  assign push    = take && !(s_q.exp_on && is_nl);
  assign eom_hit = take && ((s_q.eom_mode == EOM_NEWLINE && is_nl) || (s_q.eom_mode == EOM_CONTROL && is_ctl)
                   || (s_q.eom_mode != EOM_NONE && s_q.eom_cnt != ZERO8 && s_q.pkt_len + 8'h01 >= s_q.eom_cnt));
  assign flow_go = s_q.flow == FLOW_XON && (s_q.xoff_sent == fifo_room);
  assign flow_ch = fifo_room ? CHR_XON : CHR_XOFF;
  assign echo_go = take && !flow_go && (s_q.echo || (s_q.exp_on && is_nl));

  always_comb begin
    s_d = s_q;
    s_d.cfg_ok = 1'b0;
    s_d.cfg_err = 1'b0;
    s_d.cmd_ok = 1'b0;
    s_d.cmd_rej = 1'b0;
    s_d.close_go = 1'b0;
    s_d.stat_v = 1'b0;
    s_d.in_acc = 1'b0;
    s_d.in_ref = 1'b0;
    s_d.kill = 1'b0;
    s_d.tx_v = 1'b0;
    s_d.flush = 1'b0;
    s_d.enter = 1'b0;
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
    // ==========================================================
    // Configuration writes
    if (cfg_valid) begin
      s_d.cfg_ok = 1'b1;
      case (cfg_item)
        CFG_ENTRY: if (cfg_value[1:0] == ENTRY_IDLE || cfg_value[1:0] == ENTRY_BREAK) s_d.entry = entry_t'(cfg_value[1:0]);
                   else s_d.cfg_ok = 1'b0;
        CFG_ENTRY_SEQ: begin
          s_d.entry = ENTRY_SEQ;
          s_d.seq1 = cfg_value[15:8];
          s_d.seq2 = cfg_value[7:0];
        end
        CFG_DCD: s_d.dcd_ctl = cfg_value[0];
        CFG_DTR: if (cfg_value[9:8] == DTR_OFF || cfg_value[9:8] == DTR_ON) s_d.dtr_mode = dtr_t'(cfg_value[9:8]);
                 else if (cfg_value[9:8] == DTR_TIMED && cfg_value[7:0] != ZERO8) begin
                   s_d.dtr_mode = DTR_TIMED;
                   s_d.dtr_to = cfg_value[7:0];
                 end else s_d.cfg_ok = 1'b0;
        CFG_ECHO: s_d.echo = cfg_value[0];
        CFG_EOM: if (cfg_value[1:0] != 2'h3) begin
                   s_d.eom_mode = eom_t'(cfg_value[1:0]);
                   if (cfg_value[1:0] == EOM_NONE) s_d.eom_cnt = ZERO8;
                 end else s_d.cfg_ok = 1'b0;
        CFG_EOM_CNT: if (s_q.eom_mode != EOM_NONE) s_d.eom_cnt = cfg_value[7:0];
                     else s_d.cfg_ok = 1'b0;
        CFG_EXPAND: begin
          s_d.exp_on = cfg_value[8];
          s_d.exp_ch = cfg_value[7:0];
        end
        CFG_NEWLINE: s_d.nl_ch = cfg_value[7:0];
        CFG_FLOW: if (cfg_value[1:0] != 2'h3) s_d.flow = flow_t'(cfg_value[1:0]);
                  else s_d.cfg_ok = 1'b0;
        CFG_IDLE: s_d.idle = cfg_value[7:0];
        CFG_DISABLE: if (id_ok) s_d.dis[cfg_value[5:0]] = 1'b1;
                     else s_d.cfg_ok = 1'b0;
        CFG_ENABLE: if (id_ok) s_d.dis[cfg_value[5:0]] = 1'b0;
                    else s_d.cfg_ok = 1'b0;
        default: s_d.cfg_ok = 1'b0;
      endcase
      s_d.cfg_err = !s_d.cfg_ok;
    end
    // ==========================================================
    // Command permission check
    if (cmd_valid) begin
      if (int'(cmd_id) >= NUM_CMDS || (s_q.dis[cmd_id] && !cmd_priv)) s_d.cmd_rej = 1'b1;
      else s_d.cmd_ok = 1'b1;
    end
    // ==========================================================
    // Outcome reporting, close answer first
    if (close_ans_valid) begin
      s_d.stat_v = 1'b1;
      s_d.stat = close_answered ? ST_CLOSED : ST_ABORTED;
    end else if (close_valid) begin
      if (sess_count == '0 || (close_num_given && {1'b0, close_num} >= sess_count)
          || (!close_num_given && !close_term_ok)) begin
        s_d.stat_v = 1'b1;
        s_d.stat = ST_PARAM_ERR;
      end else begin
        s_d.close_go = 1'b1;
        s_d.close_sel = close_num_given ? close_num : 4'h0;
      end
    end else if (call_ev_valid) begin
      s_d.stat_v = 1'b1;
      case (call_ev)
        EV_PORT_BUSY, EV_ROTARY_NONE: s_d.stat = ST_PORTS_BUSY;
        EV_PORT_FULL: s_d.stat = ST_PORT_FULL;
        EV_REMOTE_FULL: s_d.stat = ST_REMOTE_FULL;
        EV_UNIT_FULL: s_d.stat = ST_UNIT_FULL;
        EV_NO_REPLY: s_d.stat = ST_NO_RESP;
        EV_OPEN_ACK: s_d.stat = open_pending ? ST_CALL_OK : ST_UNEXP_ACK;
        default: s_d.stat_v = 1'b0;
      endcase
    end
    // ==========================================================
    // DTR, RI and incoming calls
    s_d.dtr_s1 = dtr_pin;
    s_d.dtr_s2 = s_q.dtr_s1;
    s_d.dtr_old = s_q.dtr_s2;
    if (s_q.dtr_mode != DTR_OFF && s_q.dtr_old && !s_q.dtr_s2) s_d.kill = 1'b1;
    if (s_q.ring) begin
      if (s_q.dtr_s2) begin
        s_d.ring = 1'b0;
        s_d.ri = 1'b0;
        s_d.in_acc = 1'b1;
      end else if (tick) begin
        s_d.ring_cnt = s_q.ring_cnt - 8'h01;
        if (s_q.ring_cnt == 8'h01) begin
          s_d.ring = 1'b0;
          s_d.ri = 1'b0;
          s_d.in_ref = 1'b1;
        end
      end
    end else if (in_call_valid) begin
      case (s_q.dtr_mode)
        DTR_ON: begin
          s_d.in_acc = s_q.dtr_s2;
          s_d.in_ref = !s_q.dtr_s2;
        end
        DTR_TIMED: if (s_q.dtr_s2) s_d.in_acc = 1'b1;
                   else begin
                     s_d.ri = 1'b1;
                     s_d.ring = 1'b1;
                     s_d.ring_cnt = s_q.dtr_to;
                   end
        default: begin
          s_d.in_acc = 1'b1;
          if (!s_q.dtr_s2) s_d.ri = 1'b1;
        end
      endcase
    end else if (s_q.dtr_mode == DTR_OFF && s_q.dtr_s2) s_d.ri = 1'b0;
    s_d.dcd = !s_q.dcd_ctl || sess_count != '0;
    // ==========================================================
    // Command mode entry
    case (s_q.entry)
      ENTRY_IDLE: s_d.enter = take && sess_count == '0;
      ENTRY_BREAK: s_d.enter = rx_break;
      ENTRY_SEQ: s_d.enter = take && s_q.last == s_q.seq1 && rx_data == s_q.seq2;
      default: s_d.enter = 1'b0;
    endcase
    if (take) s_d.last = rx_data;
    // ==========================================================
    // Echo, expansion and flow characters
    if (flow_go) begin
      s_d.tx_v = 1'b1;
      s_d.tx_d = flow_ch;
      s_d.xoff_sent = !fifo_room;
    end else if (echo_go) begin
      s_d.tx_v = 1'b1;
      s_d.tx_d = (s_q.exp_on && is_nl) ? s_q.exp_ch : rx_data;
    end
    s_d.cts = s_q.flow != FLOW_PINS || fifo_room;
    s_d.rx_rdy = fifo_room;
    // ==========================================================
    // Packet forwarding
    if (eom_hit) begin
      s_d.flush = 1'b1;
      s_d.pkt_len = ZERO8;
      s_d.idle_cnt = ZERO8;
    end else if (push) begin
      s_d.pkt_len = s_q.pkt_len + 8'h01;
      s_d.idle_cnt = s_q.idle;
    end else if (tick && s_q.idle_cnt != ZERO8) begin
      s_d.idle_cnt = s_q.idle_cnt - 8'h01;
      if (s_q.idle_cnt == 8'h01 && s_q.pkt_len != ZERO8) begin
        s_d.flush = 1'b1;
        s_d.pkt_len = ZERO8;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.entry <= ENTRY_SEQ;
      s_q.seq1 <= CHR_ESC;
      s_q.seq2 <= CHR_DEL;
      s_q.nl_ch <= CHR_CR;
      s_q.flow <= FLOW_XON;
      s_q.idle <= IDLE_DEF;
      s_q.dcd <= 1'b1;
      s_q.cts <= 1'b1;
      s_q.stat <= ST_NONE;
      s_q.dtr_mode <= DTR_OFF;
      s_q.eom_mode <= EOM_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  line_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (fifo_in_rdy),
    .in_data   ({eom_hit, rx_data}),
    .out_valid (net_valid),
    .out_ready (net_ready),
    .out_data  ({net_eom, net_data}),
    .room      (fifo_room)
  );

  assign cfg_ok         = s_q.cfg_ok;
  assign cfg_err        = s_q.cfg_err;
  assign cmd_accept     = s_q.cmd_ok;
  assign cmd_reject     = s_q.cmd_rej;
  assign close_go       = s_q.close_go;
  assign close_sel      = s_q.close_sel;
  assign status_code    = s_q.stat;
  assign status_valid   = s_q.stat_v;
  assign in_call_accept = s_q.in_acc;
  assign in_call_refuse = s_q.in_ref;
  assign kill_all       = s_q.kill;
  assign ri             = s_q.ri;
  assign dcd            = s_q.dcd;
  assign cts            = s_q.cts;
  assign cmd_mode_enter = s_q.enter;
  assign rx_ready       = s_q.rx_rdy;
  assign tx_valid       = s_q.tx_v;
  assign tx_data        = s_q.tx_d;
  assign pkt_flush      = s_q.flush;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_dcd_held_on: assert property (!s_q.dcd_ctl |=> dcd)
    else $error("dcd dropped with control off");
  a_dtr_drop_kills: assert property (s_q.dtr_mode != DTR_OFF && $fell(s_q.dtr_s2) |=> kill_all)
    else $error("dtr fall did not terminate sessions");
  a_refuse_no_dtr: assert property (in_call_valid && !s_q.ring && s_q.dtr_mode == DTR_ON && !s_q.dtr_s2
                                    |=> in_call_refuse && !in_call_accept)
    else $error("call accepted without dtr");
  a_echo_same_byte: assert property (take && s_q.echo && !flow_go && !(s_q.exp_on && is_nl)
                                     |=> tx_valid && tx_data == $past(rx_data))
    else $error("echo byte wrong");
  a_expand_drops_nl: assert property (take && s_q.exp_on && is_nl && !(net_valid && net_ready)
                                      |=> $stable(u_fifo.s_q.cnt))
    else $error("newline pushed under expansion");
  a_unexp_ack_flag: assert property (call_ev_valid && call_ev == EV_OPEN_ACK && !open_pending
                                     && !close_valid && !close_ans_valid
                                     |=> status_valid && status_code == ST_UNEXP_ACK)
    else $error("unexpected ack not flagged");
  a_eom_cnt_needs: assert property (cfg_valid && cfg_item == CFG_EOM_CNT && s_q.eom_mode == EOM_NONE
                                    |=> cfg_err && $stable(s_q.eom_cnt))
    else $error("count accepted with eom off");
  a_disabled_reject: assert property (cmd_valid && int'(cmd_id) < NUM_CMDS && s_q.dis[cmd_id]
                                      && !cmd_priv |=> cmd_reject && !cmd_accept)
    else $error("disabled command accepted");
  a_ring_timeout: assert property (s_q.ring && !s_q.dtr_s2 && tick && s_q.ring_cnt == 8'h01
                                   |=> in_call_refuse && !ri)
    else $error("ring window end wrong");

  c_seq_entry: cover property (s_q.entry == ENTRY_SEQ ##1 cmd_mode_enter);
  c_ring_answer: cover property (s_q.ring ##[1:20] in_call_accept);
  c_idle_flush: cover property (pkt_flush && !$past(take));
  c_fifo_full: cover property (!rx_ready ##1 net_valid);
endmodule // port_session_line_control

// file: verification/user_term.sv
// Purpose: Serial user device model feeding bytes to the port
// Assumes: Bytes held until the port takes them
// Notes:   Idle data line shows the inverted last byte
`timescale 1ns/1ps
module user_term (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       go,
  input  wire logic [7:0] byte_i,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  // ==========================================================
  // Byte sender
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (go && !rx_valid) begin
      rx_valid <= 1'b1;
      rx_data  <= byte_i;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
    end
  end
endmodule // user_term

// file: verification/testbench.sv
// Purpose: Self-checking bench for the port line control
// Assumes: Tick shortened to 10 clocks
// Notes:   Random ids and bytes from a fixed seed
`timescale 1ns/1ps
module testbench;
  import port_line_pkg::*;
  logic clk, nrst, cfg_valid, cfg_ok, cfg_err, cmd_valid, cmd_priv, cmd_accept, cmd_reject, open_pending;
  logic call_ev_valid, close_valid, close_num_given, close_term_ok, close_ans_valid, close_answered, close_go;
  logic status_valid, dtr_pin, in_call_valid, in_call_accept, in_call_refuse, kill_all, ri, dcd, cts;
  logic cmd_mode_enter, rx_valid, rx_break, rx_ready, tx_valid, pkt_flush, net_valid, net_ready, net_eom, go;
  logic seen_kill = 1'b0, seen_entry = 1'b0, seen_flush = 1'b0, last_eom = 1'b0, p;
  cfg_item_t cfg_item;
  call_ev_t call_ev;
  status_t status_code;
  logic [15:0] cfg_value;
  logic [5:0] cmd_id;
  logic [4:0] sess_count;
  logic [3:0] close_num, close_sel;
  logic [7:0] rx_data, tx_data, net_data, byte_i, last_tx = 8'h00, last_net = 8'h00, b;
  int fail_count, n_tests;
  port_session_line_control #(.TICK_CYCLES(10)) dut (.*);
  user_term partner (.clk(clk), .nrst(nrst), .go(go), .byte_i(byte_i), .rx_ready(rx_ready),
                     .rx_valid(rx_valid), .rx_data(rx_data));
  // ==========================================================
  // Clock, monitors, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (kill_all) seen_kill <= 1'b1;
    if (cmd_mode_enter) seen_entry <= 1'b1;
    if (tx_valid) last_tx <= tx_data;
    if (pkt_flush) seen_flush <= 1'b1;
    if (net_valid && net_ready) last_net <= net_data;
    if (net_valid && net_ready) last_eom <= net_eom;
  end
  initial begin
    #2_000_000;
    fail_count++;
    summarize();
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cfg(input cfg_item_t i, input logic [15:0] v, input logic e);
    @(posedge clk) begin cfg_valid <= 1'b1; cfg_item <= i; cfg_value <= v; end
    @(posedge clk) cfg_valid <= 1'b0;
    #1 chk("cfg_ok cfg_err", {6'h00, !e, e}, {6'h00, cfg_ok, cfg_err});
  endtask
  task automatic stat(input status_t e);
    @(posedge clk) begin call_ev_valid <= 1'b0; close_valid <= 1'b0; close_ans_valid <= 1'b0; end
    #1 chk("status", {3'h0, 1'b1, e}, {3'h0, status_valid, status_code});
  endtask
  task automatic send(input logic [7:0] v);
    @(posedge clk) begin go <= 1'b1; byte_i <= v; end
    @(posedge clk) go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic offer_call();
    @(posedge clk) in_call_valid <= 1'b1;
    @(posedge clk) in_call_valid <= 1'b0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic status_t exp_ev(input call_ev_t v, input logic q);
    case (v)
      EV_PORT_BUSY, EV_ROTARY_NONE: return ST_PORTS_BUSY;
      EV_PORT_FULL: return ST_PORT_FULL;
      EV_REMOTE_FULL: return ST_REMOTE_FULL;
      EV_UNIT_FULL: return ST_UNIT_FULL;
      EV_NO_REPLY: return ST_NO_RESP;
      default: return q ? ST_CALL_OK : ST_UNEXP_ACK;
    endcase
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    {cfg_valid, cmd_valid, cmd_priv, open_pending, call_ev_valid, close_valid, close_ans_valid, go} = '0;
    {close_num_given, close_term_ok, close_answered, in_call_valid, rx_break} = '0;
    {nrst, dtr_pin, net_ready} = 3'b011;
    {cfg_value, cmd_id, sess_count, close_num, byte_i} = '0;
    cfg_item = CFG_ECHO;
    call_ev = EV_PORT_BUSY;
    void'($urandom(95));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("dcd cts", 8'h03, {6'h00, dcd, cts});
    for (int i = 0; i < 7; i++) begin
      p = 1'($urandom);
      @(posedge clk) begin call_ev_valid <= 1'b1; call_ev <= call_ev_t'(i); open_pending <= p; end
      stat(exp_ev(call_ev_t'(i), p));
    end
    @(posedge clk) begin close_valid <= 1'b1; close_num_given <= 1'b1; close_num <= 4'h1; close_term_ok <= 1'b1; end
    stat(ST_PARAM_ERR);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) begin close_valid <= 1'b1; sess_count <= 5'h02; close_num_given <= 1'(i == 0); end
      @(posedge clk) close_valid <= 1'b0;
      #1 chk("close_go close_sel", i ? 8'h10 : 8'h11, {3'h0, close_go, close_sel});
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) begin close_ans_valid <= 1'b1; close_answered <= 1'(i); end
      stat(i == 1 ? ST_CLOSED : ST_ABORTED);
    end
    cfg(CFG_DCD, 16'h0001, 1'b0);
    @(posedge clk) sess_count <= 5'h00;
    repeat (2) @(posedge clk);
    chk("dcd", 8'h00, {7'h00, dcd});
    cfg(CFG_DTR, 16'h0200, 1'b1);
    cfg(CFG_EOM_CNT, 16'h0004, 1'b1);
    cfg(CFG_ENABLE, 16'h0024, 1'b1);
    cfg(CFG_DISABLE, 16'h0028, 1'b1);
    b = 8'($urandom % 36);
    cfg(CFG_DISABLE, {8'h00, b}, 1'b0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) begin cmd_valid <= 1'b1; cmd_id <= b[5:0]; cmd_priv <= 1'(i); end
      @(posedge clk) cmd_valid <= 1'b0;
      #1 chk("cmd_accept cmd_reject", i ? 8'h02 : 8'h01, {6'h00, cmd_accept, cmd_reject});
    end
    send(CHR_ESC);
    send(CHR_DEL);
    chk("cmd_mode_enter", 8'h01, {7'h00, seen_entry});
    cfg(CFG_ECHO, 16'h0001, 1'b0);
    b = 8'($urandom % 26) + 8'h41;
    send(b);
    chk("echo", b, last_tx);
    cfg(CFG_EXPAND, 16'h010a, 1'b0);
    send(CHR_CR);
    chk("expand echo", 8'h0a, last_tx);
    chk("net_data", b, last_net);
    repeat (60) @(posedge clk);
    chk("pkt_flush", 8'h01, {7'h00, seen_flush});
    cfg(CFG_EOM, 16'h0002, 1'b0);
    send(8'h01);
    chk("net_eom", 8'h01, {7'h00, last_eom});
    cfg(CFG_EOM_CNT, 16'h0004, 1'b0);
    cfg(CFG_DTR, 16'h0100, 1'b0);
    @(posedge clk) dtr_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk("kill_all", 8'h01, {7'h00, seen_kill});
    offer_call();
    #1 chk("in_call_refuse ri", 8'h02, {6'h00, in_call_refuse, ri});
    cfg(CFG_DTR, 16'h0202, 1'b0);
    offer_call();
    #1 chk("ri ringing", 8'h01, {7'h00, ri});
    repeat (30) @(posedge clk);
    chk("ri window end", 8'h00, {7'h00, ri});
    cfg(CFG_DTR, 16'h0000, 1'b0);
    offer_call();
    #1 chk("in_call_accept ri", 8'h03, {6'h00, in_call_accept, ri});
    @(posedge clk) dtr_pin <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ri drop", 8'h00, {7'h00, ri});
    summarize();
  end
endmodule // testbench
